/* design/serial_eeprom_64x16_bulk_protect.sv */
// command logic of the 64x16 serial eeprom
// assumes the host drives select, serial clock and data; pins are asynchronous
`timescale 1ns/1ps
module serial_eeprom_64x16_bulk_protect
    import eeprom_pkg::*;
#(
    parameter int PROGRAM_COUNT = eeprom_pkg::PROGRAM_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // serial link pins
    input  wire logic chip_select,
    input  wire logic serial_clock_in,
    input  wire logic serial_in,
    input  wire logic bulk_program_permit,   // tie high when left open
    // serial output, two signals of the pin
    output logic      serial_out,
    output logic      serial_out_en,
    // status
    output logic      program_voltage_on,
    output logic      program_enabled
);
    import eeprom_pkg::*;

    // =========================================================
    // synchronised pins
    logic [3:0] sync;       // select, clock, data, permit
    logic       cs_s;
    logic       sk_s;
    logic       di_s;
    logic       bpe_s;
    logic       sk_d;       // previous sampled clock
    logic       cs_d;       // previous sampled select
    logic       sk_rise;
    logic       sk_fall;
    logic       cs_fall;

    pin_sync u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin_in  ({chip_select, serial_clock_in, serial_in, bulk_program_permit}),
        .pin_out (sync)
    );
    assign cs_s    = sync[3];
    assign sk_s    = sync[2];
    assign di_s    = sync[1];
    assign bpe_s   = sync[0];
    assign sk_rise = sk_s & ~sk_d;
    assign sk_fall = ~sk_s & sk_d;
    assign cs_fall = ~cs_s & cs_d;

    // =========================================================
    // state
    state_t             state;
    logic [DATA_W-1:0]  mem [WORDS];
    logic [3:0]         bit_cnt;        // counts instruction/data bits
    logic [INSTR_BITS-1:0] instr;       // opcode and address
    logic [DATA_W-1:0]  shreg;          // write data in / read data out
    logic [CNT_W-1:0]   timer;          // program cycle timer
    logic [1:0]         op;             // pending program kind
    logic               pend_all;       // pending operation hits all words
    logic               pend_write;     // pending operation writes data

    // opcode and address field helpers
    function automatic logic [1:0] f_op(input logic [INSTR_BITS-1:0] v);
        f_op = v[INSTR_BITS-1 -: OP_W];
    endfunction
    function automatic logic [ADDR_W-1:0] f_addr(input logic [INSTR_BITS-1:0] v);
        f_addr = v[ADDR_W-1:0];
    endfunction

    logic [INSTR_BITS-1:0] next_instr;
    assign next_instr = {instr[INSTR_BITS-2:0], di_s};

    // =========================================================
    // edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sk_d <= 1'b0;
            cs_d <= 1'b0;
        end else begin
            sk_d <= sk_s;
            cs_d <= cs_s;
        end
    end

    // =========================================================
    // command sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            instr      <= 8'h00;
            shreg      <= 16'h0000;
            timer      <= 17'h0_0000;
            pend_all   <= 1'b0;
            pend_write <= 1'b0;
            op         <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // first one sampled on a rising clock is the start bit
                    if (cs_s && sk_rise && di_s) begin
                        state   <= ST_INSTR;
                        bit_cnt <= 4'h0;
                    end
                end
                ST_INSTR: begin
                    if (!cs_s) begin
                        state <= ST_IDLE;
                    end else if (sk_rise) begin
                        instr   <= next_instr;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'(INSTR_BITS - 1)) begin
                            bit_cnt <= 4'h0;
                            op      <= f_op(next_instr);
                            case (f_op(next_instr))
                                OP_READ: begin
                                    shreg <= mem[f_addr(next_instr)];
                                    state <= ST_READ;
                                end
                                OP_WRITE: begin
                                    pend_all   <= 1'b0;
                                    pend_write <= 1'b1;
                                    state      <= ST_DATA;
                                end
                                OP_ERASE: begin
                                    pend_all   <= 1'b0;
                                    pend_write <= 1'b0;
                                    state      <= ST_WAIT_CS_LOW;
                                end
                                default: begin
                                    pend_all   <= 1'b1;
                                    pend_write <= (next_instr[ADDR_W-1 -: 2] == EXT_WRITE_ALL);
                                    if (next_instr[ADDR_W-1 -: 2] == EXT_WRITE_ALL) begin
                                        state <= ST_DATA;
                                    end else if (next_instr[ADDR_W-1 -: 2] == EXT_ERASE_ALL) begin
                                        state <= ST_WAIT_CS_LOW;
                                    end else begin
                                        // enable or disable acts at once; the
                                        // output stays released, so no status
                                        state <= ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_DATA: begin
                    if (!cs_s) begin
                        state <= ST_IDLE;
                    end else if (sk_rise) begin
                        shreg   <= {shreg[DATA_W-2:0], di_s};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'(DATA_W - 1)) begin
                            state <= ST_WAIT_CS_LOW;
                        end
                    end
                end
                ST_READ: begin
                    // dummy zero first, then data shifts on falling clock
                    if (!cs_s) begin
                        state <= ST_IDLE;
                    end else if (sk_fall && bit_cnt != 4'h0) begin
                        shreg <= {shreg[DATA_W-2:0], 1'b0};
                    end else if (sk_fall) begin
                        bit_cnt <= 4'h1;
                    end
                end
                ST_WAIT_CS_LOW: begin
                    // falling select starts the cycle if it is allowed
                    if (cs_fall) begin
                        if (program_enabled && (!pend_all || bpe_s)) begin
                            timer <= CNT_W'(PROGRAM_COUNT - 1);
                            state <= ST_PROGRAM;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_PROGRAM: begin
                    if (timer == 17'h0_0000) begin
                        state <= ST_DONE;
                    end else begin
                        timer <= timer - 17'h0_0001;
                    end
                end
                ST_DONE: begin
                    // stay until the host drops select once done
                    if (cs_fall || (!cs_s && !cs_d)) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // array update at the end of a program cycle, no reset on storage
    always_ff @(posedge clk) begin
        if (state == ST_PROGRAM && timer == 17'h0_0000) begin
            for (int i = 0; i < WORDS; i++) begin
                if (pend_all || i == int'(f_addr(instr))) begin
                    mem[i] <= pend_write ? shreg : ERASED_WORD;
                end
            end
        end
    end

    // =========================================================
    // programming enable latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_enabled <= 1'b0;
        end else if (state == ST_INSTR && sk_rise && cs_s &&
                     bit_cnt == 4'(INSTR_BITS - 1) && f_op(next_instr) == OP_EXT) begin
            if (next_instr[ADDR_W-1 -: 2] == EXT_PROGRAM_ENABLE) begin
                program_enabled <= 1'b1;
            end else if (next_instr[ADDR_W-1 -: 2] == EXT_PROGRAM_DISABLE) begin
                program_enabled <= 1'b0;
            end
        end
    end

    // =========================================================
    // output pin and high voltage flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out         <= 1'b0;
            serial_out_en      <= 1'b0;
            program_voltage_on <= 1'b0;
        end else begin
            program_voltage_on <= (state == ST_PROGRAM);
            if (state == ST_READ && cs_s) begin
                serial_out    <= (bit_cnt == 4'h0) ? 1'b0 : shreg[DATA_W-1];
                serial_out_en <= 1'b1;
            end else if ((state == ST_PROGRAM || state == ST_DONE) && cs_s) begin
                serial_out    <= (state == ST_DONE);
                serial_out_en <= 1'b1;
            end else begin
                serial_out    <= 1'b0;
                serial_out_en <= 1'b0;
            end
        end
    end
endmodule

/* design/eeprom_pkg.sv */
// package of constants for the 64x16 serial eeprom command logic
// assumes a 10 MHz system clock sampling the host's serial pins
//
// Functional notes
// - storage is sixty-four words of sixteen bits
// - every instruction is nine bits, seven kinds
// - start bit, two-bit opcode, six-bit address
// - programming voltage only during write or erase
// - self-timed program cycle, at most 10 ms
// - output: read data, busy status, else released
// - bulk permit high lets bulk commands run
// - bulk permit low ignores bulk commands
// - unconnected bulk permit pin reads high; the port has no pull-up here, so it must be tied high
// - enable, disable, write, erase ignore permit pin
// - read sends a zero before sixteen bits
// - powers up with programming disabled
// - status low while busy, high when done
// - opcode and extended opcode encodings
package eeprom_pkg;
    // =========================================================
    // array geometry
    localparam int WORDS       = 64;
    localparam int ADDR_W      = 6;
    localparam int DATA_W      = 16;
    localparam int OP_W        = 2;
    localparam int INSTR_BITS  = 8;    // opcode plus address after the start bit
    // =========================================================
    // opcodes
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // extended opcodes in the top two address bits
    localparam logic [1:0] EXT_PROGRAM_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL       = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL       = 2'h2;
    localparam logic [1:0] EXT_PROGRAM_ENABLE  = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // =========================================================
    // timing
    localparam int CLK_HZ               = 10_000_000;
    localparam int PROGRAM_CYCLE_TIME_US = 10_000;   // longest self-timed cycle
    localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 17;
    // command decoder states
    typedef enum logic [2:0] {
        ST_IDLE, ST_INSTR, ST_DATA, ST_READ, ST_WAIT_CS_LOW, ST_PROGRAM, ST_DONE
    } state_t;
endpackage

/* design/pin_sync.sv */
// two-flop synchroniser for the external pins
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pins
    input  wire logic [3:0] pin_in,
    output logic      [3:0] pin_out
);
    logic [3:0] meta;   // first stage, read only by the second
    // =========================================================
    // two stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta    <= 4'h0;
            pin_out <= 4'h0;
        end else begin
            meta    <= pin_in;
            pin_out <= meta;
        end
    end
endmodule

/* verification/eeprom_chk.sv */
// checker of the serial eeprom command logic, watching the top ports only
// assumes one clock domain, clk, with rst_n asynchronous and active low
`timescale 1ns/1ps
module eeprom_chk #(
    parameter int PROGRAM_COUNT = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic bulk_program_permit,
    // outputs
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic program_voltage_on,
    input wire logic program_enabled
);
    // =========================================================
    // helper: length of the current programming pulse
    logic [16:0] cnt;    // cycles with the programming voltage on
    // counts up while the voltage is on, clears when it is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= program_voltage_on ? cnt + 17'h0001 : '0;
        end
    end
    // =========================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_hiz;
        !chip_select [*6] |-> !serial_out_en;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while deselected");
    property p_v_en;
        $rose(program_voltage_on) |-> program_enabled;
    endproperty
    a_v_en: assert property (p_v_en) else $error("voltage while disabled");
    property p_v_cs;
        $rose(program_voltage_on) |-> !chip_select && !$past(chip_select);
    endproperty
    a_v_cs: assert property (p_v_cs) else $error("cycle started with select high");
    property p_v_len;
        $fell(program_voltage_on) |-> cnt == PROGRAM_COUNT;
    endproperty
    a_v_len: assert property (p_v_len) else $error("programming pulse length wrong");
    property p_busy;
        program_voltage_on && serial_out_en |-> !serial_out;
    endproperty
    a_busy: assert property (p_busy) else $error("ready shown while busy");
    property p_status;
        chip_select [*6] ##0 program_voltage_on |-> serial_out_en;
    endproperty
    a_status: assert property (p_status) else $error("status not driven");
    property p_ready;
        $fell(program_voltage_on) ##1 chip_select [*6] |-> serial_out && serial_out_en;
    endproperty
    a_ready: assert property (p_ready) else $error("ready missing after cycle");
    property p_en_cs;
        $changed(program_enabled) |-> chip_select;
    endproperty
    a_en_cs: assert property (p_en_cs) else $error("enable changed outside frame");
endmodule

bind serial_eeprom_64x16_bulk_protect eeprom_chk #(.PROGRAM_COUNT(PROGRAM_COUNT)) i_chk (
    .clk, .rst_n, .chip_select, .serial_clock_in,
    .serial_in, .bulk_program_permit,
    .serial_out, .serial_out_en,
    .program_voltage_on, .program_enabled
);

/* verification/eeprom_host.sv */
// host model: drives select, serial clock and data of the three-wire link
// assumes clk at 100 ns; serial clock 800 ns, still and low between frames
`timescale 1ns/1ps
module eeprom_host (
    // clock
    input  wire logic clk,
    // device output
    input  wire logic serial_out,
    // link pins
    output logic      chip_select,
    output logic      serial_clock_in,
    output logic      serial_in
);
    // =========================================================
    // idle levels at time zero
    initial begin
        chip_select     = 1'b0;
        serial_clock_in = 1'b0;
        serial_in       = 1'b0;
    end
    // waits n clocks, then steps 1 ns past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // moves select, holding it 1.2 us so low time is kept
    task automatic sel(input logic v);
        chip_select = v;
        tick(12);
    endtask
    // sends n bits msb first, sampling the output late in each high phase
    task automatic shift(input logic [26:0] b, input int n, output logic [16:0] rd);
        rd = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = b[i];
            tick(3);
            serial_clock_in = 1'b1;
            tick(5);
            rd = {rd[15:0], serial_out};
            serial_clock_in = 1'b0;
        end
        // released data line shows the inverse of its last bit
        serial_in = ~serial_in;
    endtask
endmodule

/* verification/tb_top.sv */
// testbench of the serial eeprom command logic
// assumes the host model in eeprom_host.sv and the bound checker
`timescale 1ns/1ps
module tb_top;
    import eeprom_pkg::*;
    // =========================================================
    // signals and counters
    logic clk;                   // 10 MHz clock
    logic rst_n;                 // reset, active low
    logic permit;                // bulk permit, 1 stands for unconnected
    logic cs, sck, sdi, sdo, sdo_en, volt, pen;
    logic v_seen = 1'b0;         // voltage seen during last operation
    int   fails = 0;
    int   checks_done = 0;
    `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
        $display("[FAIL] %0t value %h expected %h", $time, a, e); end end
    always #50 clk = ~clk;
    // notes any programming voltage
    always @(posedge clk) if (volt === 1'b1) v_seen <= 1'b1;
    serial_eeprom_64x16_bulk_protect #(.PROGRAM_COUNT(40)) i_dut (
        .clk(clk), .rst_n(rst_n), .chip_select(cs), .serial_clock_in(sck),
        .serial_in(sdi), .bulk_program_permit(permit), .serial_out(sdo),
        .serial_out_en(sdo_en), .program_voltage_on(volt), .program_enabled(pen));
    eeprom_host i_host (.clk(clk), .serial_out(sdo), .chip_select(cs),
        .serial_clock_in(sck), .serial_in(sdi));
    // =========================================================
    // verdict
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one instruction; run tells whether a self-timed cycle must follow
    task automatic prog(input logic [26:0] b, input int n, input logic run);
        logic [16:0] rd;
        int k;
        v_seen = 1'b0;
        i_host.sel(1'b1);
        i_host.shift(b, n, rd);
        `CHK(sdo_en, 1'b0)
        i_host.sel(1'b0);
        `CHK(v_seen, run)
        if (run) begin
            i_host.sel(1'b1);
            `CHK(sdo_en, 1'b1)
            `CHK(sdo, 1'b0)
            k = 0;
            while (sdo !== 1'b1 && k < 400) begin
                i_host.tick(1);
                k++;
            end
            if (k == 400) begin
                fails++;
                stop_test();
            end
            i_host.tick(8);
            i_host.sel(1'b0);
        end
    endtask
    // reads one word after two leading zeros before the start bit
    task automatic rdw(input logic [5:0] a, input logic [15:0] e);
        logic [16:0] rd;
        i_host.sel(1'b1);
        i_host.shift({2'b00, 1'b1, OP_READ, a, 16'h0000}, 27, rd);
        `CHK(rd, {1'b0, e})
        i_host.sel(1'b0);
        `CHK(sdo_en, 1'b0)
    endtask
    // =========================================================
    // main sequence
    initial begin
        clk    = 1'b0;
        rst_n  = 1'b0;
        permit = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        i_host.tick(3);
        `CHK(pen, 1'b0)
        `CHK(sdo_en, 1'b0)
        prog({3'b001, OP_WRITE, 6'h05, 16'h0000}, 25, 1'b0);
        prog({19'h1, OP_EXT, EXT_PROGRAM_ENABLE, 4'h0}, 9, 1'b0);
        `CHK(pen, 1'b1)
        prog({3'b001, OP_WRITE, 6'h05, 16'ha5a5}, 25, 1'b1);
        rdw(6'h05, 16'ha5a5);
        prog({3'b001, OP_WRITE, 6'h06, 16'h5a5a}, 25, 1'b1);
        rdw(6'h06, 16'h5a5a);
        prog({19'h1, OP_ERASE, 6'h06}, 9, 1'b1);
        rdw(6'h06, ERASED_WORD);
        $display("test single word done");
        permit = 1'b0;
        prog({3'b001, OP_EXT, EXT_WRITE_ALL, 4'h0, 16'h1234}, 25, 1'b0);
        prog({19'h1, OP_EXT, EXT_ERASE_ALL, 4'h0}, 9, 1'b0);
        rdw(6'h05, 16'ha5a5);
        prog({19'h1, OP_ERASE, 6'h05}, 9, 1'b1);
        rdw(6'h05, ERASED_WORD);
        permit = 1'b1;
        prog({3'b001, OP_EXT, EXT_WRITE_ALL, 4'h0, 16'h0f0f}, 25, 1'b1);
        rdw(6'h3f, 16'h0f0f);
        rdw(6'h00, 16'h0f0f);
        $display("test bulk permit done");
        prog({19'h1, OP_EXT, EXT_PROGRAM_DISABLE, 4'h0}, 9, 1'b0);
        `CHK(pen, 1'b0)
        prog({19'h1, OP_ERASE, 6'h3f}, 9, 1'b0);
        prog({19'h1, OP_EXT, EXT_ERASE_ALL, 4'h0}, 9, 1'b0);
        rdw(6'h3f, 16'h0f0f);
        prog({19'h1, OP_EXT, EXT_PROGRAM_ENABLE, 4'h0}, 9, 1'b0);
        prog({19'h1, OP_EXT, EXT_ERASE_ALL, 4'h0}, 9, 1'b1);
        rdw(6'h00, ERASED_WORD);
        $display("test protection done");
        stop_test();
    end
endmodule
